// ===== common/pmr_pkg.sv
// Shared constants and types for the power mode and reset source controller.
// Assumes a 50 MHz system clock and a byte-addressed Avalon-MM register slave.
package pmr_pkg;
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned LOST_CLK_TIMEOUT_US = 100;
  localparam int unsigned LOST_CLK_TIMEOUT_CYC = LOST_CLK_TIMEOUT_US * CLK_MHZ;
  localparam int unsigned WDT_PRESCALE = 12;
  localparam logic [3:0] WDT_PRE_LAST = 4'(WDT_PRESCALE - 1);
  localparam logic [7:0] RST_HOLD_CYC = 8'h08;
  localparam logic [15:0] USER_CODE_TOP = 16'h3DFF;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;

  localparam logic [7:0] OFS_POWER_CONTROL = 8'h00;
  localparam logic [7:0] OFS_OSC_CONTROL = 8'h04;
  localparam logic [7:0] OFS_CLOCK_SELECT = 8'h08;
  localparam logic [7:0] OFS_RESET_SOURCE = 8'h0C;
  localparam logic [7:0] OFS_CONFIG = 8'h10;
  localparam logic [7:0] OFS_WATCHDOG = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  localparam int unsigned BIT_STOP_SEL = 1;
  localparam int unsigned BIT_SUSPEND = 5;
  localparam int unsigned BIT_SW_RESET = 4;
  localparam int unsigned BIT_CMP_RESET = 5;
  localparam int unsigned BIT_CFG_CMP_WAKE = 0;
  localparam int unsigned BIT_CFG_T3_EXT = 1;
  localparam int unsigned BIT_CFG_LOST_CLK_EN = 3;
  localparam int unsigned BIT_WDT_EN = 8;

  localparam logic [6:0] CAUSE_POR = 7'h01;
  localparam logic [6:0] CAUSE_PIN = 7'h02;
  localparam logic [6:0] CAUSE_LOST_CLK = 7'h04;
  localparam logic [6:0] CAUSE_WDT = 7'h08;
  localparam logic [6:0] CAUSE_SW = 7'h10;
  localparam logic [6:0] CAUSE_CMP = 7'h20;
  localparam logic [6:0] CAUSE_FERR = 7'h40;
  localparam logic [6:0] CAUSE_NONE = 7'h00;

  localparam logic [2:0] CLK_DIVIDE_RST = 3'h0;
  localparam logic [7:0] WDT_LIMIT_RST = 8'hFF;

  typedef enum logic [1:0] {PMR_RUN, PMR_STOP, PMR_SUSP, PMR_RST} pmr_state_type;
endpackage

// ===== logic/pmr_sync.sv
// Two-flop synchroniser for levels that arrive from pins.
// Assumes the inputs are slow levels; the first stage feeds only the second.
module pmr_sync import pmr_pkg::*; #(
  parameter int unsigned WIDTH = 3
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] asyncIn,
  input wire logic [WIDTH-1:0] rstVal,
  output logic [WIDTH-1:0] syncOut
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } pmr_sync_state_type;

  pmr_sync_state_type r;
  pmr_sync_state_type nxt;

  always_comb begin
    nxt.meta = asyncIn;
    nxt.stable = r.meta;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r <= {rstVal, rstVal};
    end else begin
      r <= nxt;
    end
  end

  // Reset value shows until the first sampled level has passed both stages.
  assign syncOut = r.stable;
endmodule

// ===== logic/pmr_wdt.sv
// Watchdog counter of the counter array, ticking at one twelfth of the system clock.
// Assumes clear comes from a registered reset and kick is a one-cycle pulse.
module pmr_wdt import pmr_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic runEn,
  input wire logic kick,
  input wire logic [7:0] limit,
  output logic expire,
  output logic [7:0] count
);
  typedef struct packed {
    logic [3:0] pre;
    logic [7:0] cnt;
    logic expire;
  } pmr_wdt_state_type;

  pmr_wdt_state_type r;
  pmr_wdt_state_type nxt;

  always_comb begin
    nxt = r;
    nxt.expire = 1'b0;
    if (clear || kick) begin
      nxt.pre = '0;
      nxt.cnt = '0;
    end else if (runEn) begin
      nxt.pre = (r.pre == WDT_PRE_LAST) ? 4'h0 : 4'(r.pre + 4'h1);
      if (r.pre == WDT_PRE_LAST) begin
        if (r.cnt == limit) begin
          nxt.expire = 1'b1;
          nxt.cnt = '0;
        end else begin
          nxt.cnt = 8'(r.cnt + 8'h01);
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end

  assign expire = r.expire;
  assign count = r.cnt;
endmodule

// ===== logic/pmr_ctrl.sv
// Power mode and internal reset source controller with Avalon-MM registers.
// Assumes the core gives a one-cycle instruction-done pulse and same-clock event pulses.
module pmr_ctrl import pmr_pkg::*; #(
  parameter logic [15:0] LOST_CLK_CYC = 16'(LOST_CLK_TIMEOUT_CYC)
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rstPinN,
  input wire logic cmpOut,
  input wire logic portMatch,
  input wire logic cpuInstrDone,
  input wire logic timer2Ovf,
  input wire logic capSenseGt,
  input wire logic programStoreWriteEnable,
  input wire logic flashWrite,
  input wire logic codeRead,
  input wire logic progFetch,
  input wire logic [15:0] flashAddr,
  input wire logic flashSecBlocked,
  output logic cpuHalt,
  output logic intOscStop,
  output logic periphStop,
  output logic timer3Run,
  output logic portMatchRun,
  output logic coreRst,
  output logic coreResume,
  output logic cpuLoadPc,
  output logic [15:0] cpuPcValue,
  output logic [2:0] clockDivide
);
  typedef struct packed {
    pmr_state_type st;
    logic [7:0] holdCnt;
    logic [15:0] lostClkCnt;
    logic [6:0] cause;
    logic cmpRstEn;
    logic lostClkEn;
    logic cmpWakeEn;
    logic t3Ext;
    logic stopPend;
    logic suspPend;
    logic [2:0] clkDiv;
    logic wdtEn;
    logic [7:0] wdtLimit;
    logic wdtKick;
    logic waitReq;
    logic [31:0] rdata;
    logic cpuHalt;
    logic oscStop;
    logic periphStop;
    logic t3Run;
    logic pmRun;
    logic coreRst;
    logic coreResume;
    logic loadPc;
    logic [15:0] pcValue;
  } pmr_ctrl_state_type;

  pmr_ctrl_state_type r;
  pmr_ctrl_state_type nxt;
  logic [2:0] syncLvl;
  logic pinLowS;
  logic cmpS;
  logic portMatchS;
  logic wdtExpire;
  logic [7:0] wdtCount;
  logic doWrite;
  logic flashErr;
  logic [6:0] newCause;

  // Every reset restores control state; the cause field holds only the new cause.
  function automatic pmr_ctrl_state_type resetState(input logic [6:0] cause);
    pmr_ctrl_state_type s;
    s = '0;
    s.st = PMR_RST;
    s.holdCnt = RST_HOLD_CYC;
    s.cause = cause;
    s.wdtEn = 1'b1;
    s.wdtLimit = WDT_LIMIT_RST;
    s.clkDiv = CLK_DIVIDE_RST;
    s.waitReq = 1'b1;
    s.cpuHalt = 1'b1;
    s.oscStop = 1'b0;
    s.periphStop = 1'b1;
    s.coreRst = 1'b1;
    s.pcValue = RESET_VECTOR;
    return s;
  endfunction

  pmr_sync #(.WIDTH(3)) uSync (
    .sys_clk(sys_clk),
    .rst(rst),
    .asyncIn({~rstPinN, cmpOut, portMatch}),
    .rstVal(3'h2),
    .syncOut(syncLvl)
  );

  assign pinLowS = syncLvl[2];
  assign cmpS = syncLvl[1];
  assign portMatchS = syncLvl[0];

  pmr_wdt uWdt (
    .sys_clk(sys_clk),
    .rst(rst),
    .clear(r.coreRst),
    .runEn(r.wdtEn && r.st == PMR_RUN),
    .kick(r.wdtKick),
    .limit(r.wdtLimit),
    .expire(wdtExpire),
    .count(wdtCount)
  );

  assign doWrite = avs_write && !r.waitReq;

  always_comb begin
    flashErr = (flashWrite && programStoreWriteEnable && flashAddr > USER_CODE_TOP)
      || (codeRead && flashAddr > USER_CODE_TOP)
      || (progFetch && flashAddr > USER_CODE_TOP)
      || flashSecBlocked;
  end

  always_comb begin
    nxt = r;
    nxt.coreResume = 1'b0;
    nxt.loadPc = 1'b0;
    nxt.wdtKick = 1'b0;
    newCause = CAUSE_NONE;
    if ((avs_read || avs_write) && r.waitReq) begin
      nxt.waitReq = 1'b0;
      unique case (avs_address)
        OFS_POWER_CONTROL: nxt.rdata = 32'(r.stopPend) << BIT_STOP_SEL;
        OFS_OSC_CONTROL: nxt.rdata = 32'(r.suspPend) << BIT_SUSPEND;
        OFS_CLOCK_SELECT: nxt.rdata = 32'(r.clkDiv);
        OFS_RESET_SOURCE: nxt.rdata = 32'(r.cause);
        OFS_CONFIG: nxt.rdata = 32'({r.lostClkEn, r.cmpRstEn, r.t3Ext, r.cmpWakeEn});
        OFS_WATCHDOG: nxt.rdata = 32'({r.wdtEn, r.wdtLimit});
        OFS_STATUS: nxt.rdata = 32'({wdtCount, 6'h00, r.st});
        default: nxt.rdata = 32'h0000_0000;
      endcase
    end else begin
      nxt.waitReq = 1'b1;
    end
    if (doWrite) begin
      unique case (avs_address)
        OFS_POWER_CONTROL: nxt.stopPend = avs_writedata[BIT_STOP_SEL];
        OFS_OSC_CONTROL: nxt.suspPend = avs_writedata[BIT_SUSPEND];
        OFS_CLOCK_SELECT: nxt.clkDiv = avs_writedata[2:0];
        OFS_RESET_SOURCE: begin
          if (avs_writedata[BIT_CMP_RESET]) begin
            nxt.cmpRstEn = 1'b1;
          end
        end
        OFS_CONFIG: begin
          nxt.cmpWakeEn = avs_writedata[BIT_CFG_CMP_WAKE];
          nxt.t3Ext = avs_writedata[BIT_CFG_T3_EXT];
          nxt.lostClkEn = avs_writedata[BIT_CFG_LOST_CLK_EN];
        end
        OFS_WATCHDOG: begin
          nxt.wdtLimit = avs_writedata[7:0];
          nxt.wdtEn = avs_writedata[BIT_WDT_EN];
          nxt.wdtKick = 1'b1;
        end
        default: begin
        end
      endcase
    end
    unique case (r.st)
      PMR_RUN: begin
        if (cpuInstrDone && r.stopPend) begin
          nxt.st = PMR_STOP;
          nxt.stopPend = 1'b0;
          nxt.lostClkCnt = '0;
        end else if (cpuInstrDone && r.suspPend) begin
          nxt.st = PMR_SUSP;
          nxt.suspPend = 1'b0;
        end
      end
      PMR_STOP: begin
        if (r.lostClkEn) begin
          nxt.lostClkCnt = 16'(r.lostClkCnt + 16'h0001);
        end
      end
      PMR_SUSP: begin
        if (portMatchS || timer2Ovf || capSenseGt || (r.cmpWakeEn && !cmpS)) begin
          nxt.st = PMR_RUN;
          nxt.coreResume = 1'b1;
        end
      end
      PMR_RST: begin
        if (r.holdCnt != 8'h00) begin
          nxt.holdCnt = 8'(r.holdCnt - 8'h01);
        end else if (!pinLowS) begin
          nxt.st = PMR_RUN;
          nxt.loadPc = 1'b1;
        end
      end
    endcase
    if (pinLowS && r.st != PMR_RST) begin
      newCause = CAUSE_PIN;
    end else if (r.cmpRstEn && !cmpS && r.st != PMR_RST) begin
      newCause = CAUSE_CMP;
    end else if (r.st == PMR_STOP && r.lostClkEn && r.lostClkCnt >= LOST_CLK_CYC - 16'h0001) begin
      newCause = CAUSE_LOST_CLK;
    end else if (r.st == PMR_RUN && wdtExpire) begin
      newCause = CAUSE_WDT;
    end else if (r.st == PMR_RUN && flashErr) begin
      newCause = CAUSE_FERR;
    end else if (doWrite && avs_address == OFS_RESET_SOURCE && avs_writedata[BIT_SW_RESET]) begin
      newCause = CAUSE_SW;
    end
    if (newCause != CAUSE_NONE) begin
      nxt = resetState(newCause);
    end
    nxt.cpuHalt = nxt.st != PMR_RUN;
    nxt.oscStop = nxt.st == PMR_STOP || nxt.st == PMR_SUSP;
    nxt.periphStop = nxt.st != PMR_RUN;
    nxt.t3Run = nxt.st == PMR_RUN || (nxt.st == PMR_SUSP && nxt.t3Ext);
    nxt.pmRun = nxt.st == PMR_RUN || nxt.st == PMR_SUSP;
    nxt.coreRst = nxt.st == PMR_RST;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r <= resetState(CAUSE_POR);
    end else begin
      r <= nxt;
    end
  end

  assign avs_readdata = r.rdata;
  assign avs_waitrequest = r.waitReq;
  assign cpuHalt = r.cpuHalt;
  assign intOscStop = r.oscStop;
  assign periphStop = r.periphStop;
  assign timer3Run = r.t3Run;
  assign portMatchRun = r.pmRun;
  assign coreRst = r.coreRst;
  assign coreResume = r.coreResume;
  assign cpuLoadPc = r.loadPc;
  assign cpuPcValue = r.pcValue;
  assign clockDivide = r.clkDiv;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_stop_entry: assert property (
    r.st == PMR_RUN && r.stopPend && cpuInstrDone && !pinLowS && !(r.cmpRstEn && !cmpS)
      && !wdtExpire && !flashErr && !doWrite |=> r.st == PMR_STOP ##0 cpuHalt)
    else $error("stop not entered after instruction completed");

  a_stop_halt: assert property (
    r.st == PMR_STOP |-> cpuHalt && intOscStop && periphStop && !timer3Run)
    else $error("stop mode left logic running");

  a_stop_exit: assert property (
    r.st == PMR_STOP ##1 r.st != PMR_STOP |-> r.st == PMR_RST && coreRst)
    else $error("stop ended without a reset");

  a_lost_clock: assert property (
    r.st == PMR_STOP && r.lostClkEn && r.lostClkCnt == LOST_CLK_CYC - 16'h0001 |=> r.st == PMR_RST)
    else $error("missing clock timeout did not reset");

  a_susp_wake: assert property (
    r.st == PMR_SUSP && (portMatchS || timer2Ovf || capSenseGt) |=> r.st inside {PMR_RUN, PMR_RST})
    else $error("suspend not ended by wake event");

  a_wake_resume: assert property (
    r.st == PMR_SUSP ##1 r.st == PMR_RUN |-> coreResume && !cpuLoadPc)
    else $error("suspend wake did not resume in place");

  a_reset_vector: assert property (
    $fell(coreRst) |-> cpuLoadPc && cpuPcValue == RESET_VECTOR ##1 !cpuLoadPc)
    else $error("reset exit did not load address zero");

  a_cmp_reset: assert property (
    r.cmpRstEn && !cmpS && !pinLowS && r.st != PMR_RST |=> r.cause == CAUSE_CMP && coreRst)
    else $error("comparator low did not reset");

  a_one_cause: assert property (
    $rose(coreRst) |-> $onehot(r.cause) && r.wdtEn && !r.cmpRstEn)
    else $error("reset did not record exactly one cause");

  a_susp_entry: assert property (
    r.st == PMR_RUN && !r.stopPend && r.suspPend && cpuInstrDone && newCause == CAUSE_NONE
      |=> r.st == PMR_SUSP && cpuHalt && intOscStop)
    else $error("suspend not entered after instruction completed");

  a_susp_hold: assert property (
    r.st == PMR_SUSP |-> cpuHalt && periphStop && portMatchRun && timer3Run == r.t3Ext)
    else $error("suspend left logic running");

  a_state_kept: assert property (
    r.st == PMR_SUSP && !doWrite ##1 r.st == PMR_RUN
      |-> $stable(r.cause) && $stable(r.clkDiv) && $stable(r.wdtLimit))
    else $error("suspend wake lost register state");

  a_cmp_wake: assert property (
    r.st == PMR_SUSP && r.cmpWakeEn && !cmpS |=> r.st inside {PMR_RUN, PMR_RST})
    else $error("comparator low did not end suspend");

  a_match_level: assert property (
    r.st == PMR_SUSP && $past(r.st) == PMR_RUN && portMatchS |=> r.st != PMR_SUSP)
    else $error("standing port match did not wake");

  a_cmp_enable: assert property (
    doWrite && avs_address == OFS_RESET_SOURCE && avs_writedata[BIT_CMP_RESET] && newCause == CAUSE_NONE
      |=> r.cmpRstEn)
    else $error("comparator reset enable not set");

  a_cause_flag: assert property (
    $rose(coreRst) |-> (r.cause == CAUSE_CMP) == $past(r.cmpRstEn && !cmpS && !pinLowS))
    else $error("comparator flag does not match reset cause");

  a_watchdog_reset: assert property (
    r.st == PMR_RUN && wdtExpire && !pinLowS && !(r.cmpRstEn && !cmpS) |=> coreRst && r.cause == CAUSE_WDT)
    else $error("watchdog expiry did not reset");

  a_flash_reset: assert property (
    r.st == PMR_RUN && flashErr && !wdtExpire && !pinLowS && !(r.cmpRstEn && !cmpS)
      |=> coreRst && r.cause == CAUSE_FERR)
    else $error("flash error did not reset");

  a_soft_reset: assert property (
    doWrite && avs_address == OFS_RESET_SOURCE && avs_writedata[BIT_SW_RESET] |=> coreRst)
    else $error("software reset request ignored");

  a_watchdog_cleared: assert property (
    coreRst |=> wdtCount == 8'h00)
    else $error("watchdog not restarted by reset");
endmodule

// ===== test/pmr_ctrl_tb.sv
// Self-checking bench for the power mode and reset source controller.
// Assumes pmr_pkg and the design files are compiled first; the bench drives every port.
module pmr_ctrl_tb import pmr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic rstPinN = 1'b1, cmpOut = 1'b1, portMatch = 1'b0, cpuInstrDone = 1'b0;
  logic timer2Ovf = 1'b0, capSenseGt = 1'b0, programStoreWriteEnable = 1'b0;
  logic flashWrite = 1'b0, codeRead = 1'b0, progFetch = 1'b0, flashSecBlocked = 1'b0;
  logic [15:0] flashAddr = 16'h0000;
  logic cpuHalt, intOscStop, periphStop, timer3Run, portMatchRun, coreRst, coreResume, cpuLoadPc;
  logic [15:0] cpuPcValue;
  logic [2:0] clockDivide;
  int mismatches = 0;
  int n_checks = 0;
  logic [31:0] rd;
  bit hit;

  pmr_ctrl #(.LOST_CLK_CYC(16'h0028)) uut (
    .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rstPinN(rstPinN), .cmpOut(cmpOut), .portMatch(portMatch),
    .cpuInstrDone(cpuInstrDone), .timer2Ovf(timer2Ovf), .capSenseGt(capSenseGt),
    .programStoreWriteEnable(programStoreWriteEnable), .flashWrite(flashWrite), .codeRead(codeRead),
    .progFetch(progFetch), .flashAddr(flashAddr), .flashSecBlocked(flashSecBlocked),
    .cpuHalt(cpuHalt), .intOscStop(intOscStop), .periphStop(periphStop), .timer3Run(timer3Run),
    .portMatchRun(portMatchRun), .coreRst(coreRst), .coreResume(coreResume), .cpuLoadPc(cpuLoadPc),
    .cpuPcValue(cpuPcValue), .clockDivide(clockDivide)
  );

  always #10 sys_clk = ~sys_clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One Avalon-MM transfer; read data lands in rd.
  task automatic bus(input bit we, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= we;
    avs_read <= !we;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Waits for 0 reset, 1 program counter load, 2 resume.
  task automatic waitSig(input int which, input int lim);
    hit = 0;
    for (int i = 0; i < lim && !hit; i++) begin
      @(posedge sys_clk);
      case (which)
        0: hit = coreRst === 1'b1;
        1: hit = cpuLoadPc === 1'b1;
        default: hit = coreResume === 1'b1;
      endcase
    end
  endtask

  task automatic pulse(input int k);
    @(posedge sys_clk);
    case (k)
      0: cpuInstrDone <= 1'b1;
      1: timer2Ovf <= 1'b1;
      2: capSenseGt <= 1'b1;
      3: flashWrite <= 1'b1;
      4: codeRead <= 1'b1;
      5: progFetch <= 1'b1;
      default: flashSecBlocked <= 1'b1;
    endcase
    @(posedge sys_clk);
    {cpuInstrDone, timer2Ovf, capSenseGt, flashWrite, codeRead, progFetch, flashSecBlocked} <= 7'h00;
  endtask

  task automatic expectReset(input int lim, input logic [6:0] cause);
    waitSig(0, lim);
    chk(hit, 1, "reset asserted");
    waitSig(1, 40);
    chk(hit, 1, "reset release");
    chk(cpuPcValue, RESET_VECTOR, "restart address");
    bus(0, OFS_RESET_SOURCE, 32'h0000_0000);
    chk(rd[6:0], cause, "reset cause");
  endtask

  task automatic testSuspend();
    logic [1:0] cfg;
    for (int k = 0; k < 5; k++) begin
      cfg = {k[0], k == 3};
      bus(1, OFS_CONFIG, {30'h0000_0000, cfg});
      bus(1, OFS_CLOCK_SELECT, 32'h0000_0000);
      bus(1, OFS_OSC_CONTROL, 32'h0000_0020);
      portMatch <= (k == 4);
      pulse(1);
      pulse(0);
      if (k == 4) begin
        waitSig(2, 10);
        chk(hit, 1, "standing match wake");
      end else begin
        repeat (3) @(posedge sys_clk);
        chk({cpuHalt, intOscStop, periphStop, portMatchRun, timer3Run}, {4'hF, cfg[1]}, "suspend outputs");
        chk(clockDivide, 3'h0, "divide by one");
        bus(0, OFS_STATUS, 32'h0000_0000);
        chk(rd[1:0], 2'h2, "suspend despite pending");
        case (k)
          0: pulse(1);
          1: pulse(2);
          2: portMatch <= 1'b1;
          default: cmpOut <= 1'b0;
        endcase
        waitSig(2, 10);
        chk(hit, 1, "wake event");
      end
      portMatch <= 1'b0;
      cmpOut <= 1'b1;
      @(posedge sys_clk);
      chk({coreRst, cpuHalt, cpuLoadPc}, 3'h0, "resume without reset");
      bus(0, OFS_CONFIG, 32'h0000_0000);
      chk(rd[1:0], cfg, "state kept");
    end
  endtask

  task automatic testStop();
    bus(1, OFS_CONFIG, 32'h0000_0008);
    bus(1, OFS_POWER_CONTROL, 32'h0000_0002);
    pulse(0);
    repeat (2) @(posedge sys_clk);
    chk({cpuHalt, intOscStop, periphStop, portMatchRun, timer3Run}, 5'h1C, "stop outputs");
    bus(0, OFS_STATUS, 32'h0000_0000);
    chk(rd[1:0], 2'h1, "stop entered");
    pulse(1);
    waitSig(2, 4);
    chk(hit, 0, "no wake from stop");
    expectReset(60, CAUSE_LOST_CLK);
  endtask

  task automatic testFlash();
    programStoreWriteEnable <= 1'b1;
    for (int k = 3; k < 7; k++) begin
      flashAddr <= USER_CODE_TOP;
      pulse(k < 6 ? k : 4);
      waitSig(0, 4);
      chk(hit, 0, "legal top access");
      flashAddr <= USER_CODE_TOP + 16'h0001;
      pulse(k);
      expectReset(6, CAUSE_FERR);
    end
  endtask

  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    waitSig(1, 40);
    chk(hit, 1, "power-on release");
    bus(0, OFS_RESET_SOURCE, 32'h0000_0000);
    chk(rd[6:0], CAUSE_POR, "power-on cause");
    bus(0, OFS_WATCHDOG, 32'h0000_0000);
    chk(rd[8:0], 9'h1FF, "watchdog after reset");
    bus(0, 8'h40, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "unmapped read");
    bus(1, OFS_CLOCK_SELECT, 32'h0000_0005);
    @(posedge sys_clk);
    chk(clockDivide, 3'h5, "clock divide");
    testSuspend();
    testStop();
    bus(1, OFS_RESET_SOURCE, 32'h0000_0020);
    bus(0, OFS_CONFIG, 32'h0000_0000);
    chk(rd[2], 1, "comparator reset enable");
    cmpOut <= 1'b0;
    expectReset(10, CAUSE_CMP);
    cmpOut <= 1'b1;
    testFlash();
    bus(1, OFS_WATCHDOG, 32'h0000_0102);
    waitSig(0, 10);
    chk(hit, 0, "watchdog early");
    expectReset(60, CAUSE_WDT);
    bus(0, OFS_WATCHDOG, 32'h0000_0000);
    chk(rd[8:0], 9'h1FF, "watchdog re-enabled");
    bus(1, OFS_RESET_SOURCE, 32'h0000_0010);
    expectReset(6, CAUSE_SW);
    bus(1, OFS_POWER_CONTROL, 32'h0000_0002);
    pulse(0);
    rstPinN <= 1'b0;
    repeat (14) @(posedge sys_clk);
    chk(coreRst, 1, "pin held low");
    rstPinN <= 1'b1;
    expectReset(6, CAUSE_PIN);
    results();
  end

  initial begin
    #200000;
    mismatches++;
    $display("mismatch run time expected finish seen timeout");
    results();
  end
endmodule
